/* File: logic/analog_indicator_loop.sv */
// Status bit bank of one analog indicator loop, word and coil access
`timescale 1ns/10ps
module analog_indicator_loop (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Loop identity and scan
  input  wire logic [3:0]  loop_number,
  input  wire logic        scan_tick,
  // Word access
  input  wire logic        word_wr,
  input  wire logic        word_sel,
  input  wire logic [15:0] word_wdata,
  // Coil access
  input  wire logic        coil_wr,
  input  wire logic        coil_rd,
  input  wire logic [15:0] coil_addr,
  input  wire logic        coil_wdata,
  // Alarm and event sources
  input  wire logic [7:0]  alarm_active,
  input  wire logic [7:0]  alarm_raise,
  input  wire logic        config_changed_flag,
  input  wire logic        active_event_flag,
  input  wire logic        loop_event_raise,
  input  wire logic [2:0]  button_sustained,
  // Outputs
  output logic [15:0]      loop_alarm_and_switch_word,
  output logic [15:0]      loop_alarm_and_event_word,
  output logic             coil_rdata,
  output logic             coil_hit,
  output logic [7:0]       alarm_unacked,
  output logic [7:0]       alarm_enabled,
  output logic             first_word_alarms_off_service,
  output logic             second_word_alarms_off_service,
  output logic             unacked_event_flag,
  output logic [2:0]       switch_input_state
);
  logic [15:0] loop_base;
  logic [15:0] coil_ofs;
  logic [1:0]  coil_word;
  logic [3:0]  coil_bit;
  logic [15:0] wr_data;
  logic [15:0] wr_mask1;
  logic [15:0] wr_mask2;
  logic [15:0] next_w1;
  logic [15:0] next_w2;
  logic [7:0]  alarm_act_q;
  logic        cfg_q;
  logic        act_evt_q;
  logic [2:0]  press;

  // Coil address decode
  always_comb begin
    loop_base = package_base(loop_number);
    coil_ofs  = coil_addr - loop_base;
    coil_bit  = coil_ofs[3:0];
    if (coil_addr < loop_base || coil_ofs >= 16'd32) begin
      coil_word = indicator_pkg::WORD_SEL_NONE;
    end else if (coil_ofs < indicator_pkg::COIL_WORD2_OFS) begin
      coil_word = indicator_pkg::WORD_SEL_ONE;
    end else begin
      coil_word = indicator_pkg::WORD_SEL_TWO;
    end
  end

  function automatic logic [15:0] package_base(input logic [3:0] n);
    logic [15:0] idx;
    idx = {12'h000, n} - 16'd1;
    return indicator_pkg::COIL_BASE + 16'(idx * indicator_pkg::COIL_LOOP_STEP);
  endfunction : package_base

  // Write masks and data for either word
  always_comb begin
    wr_data  = 16'h0000;
    wr_mask1 = 16'h0000;
    wr_mask2 = 16'h0000;
    if (word_wr) begin
      wr_data = word_wdata;
      if (word_sel) begin
        wr_mask2 = 16'hFFFF;
      end else begin
        wr_mask1 = 16'hFFFF;
      end
    end else if (coil_wr) begin
      wr_data = {16{coil_wdata}};
      if (coil_word == indicator_pkg::WORD_SEL_ONE) begin
        wr_mask1 = 16'h0001 << coil_bit;
      end else if (coil_word == indicator_pkg::WORD_SEL_TWO) begin
        wr_mask2 = 16'h0001 << coil_bit;
      end
    end
  end

  // Alarm triplets, unacked bit set by the alarm block winning over a clear
  generate
    for (genvar a = 0; a < indicator_pkg::ALARMS * 2; a++) begin : g_alarm
      localparam int unsigned P = (a % 4) * 3;
      logic m_n;
      logic m_e;
      logic d_n;
      logic d_e;
      assign m_n = (a < 4) ? wr_mask1[P + indicator_pkg::BIT_UNACKED]
                           : wr_mask2[P + indicator_pkg::BIT_UNACKED];
      assign m_e = (a < 4) ? wr_mask1[P + indicator_pkg::BIT_ENABLED]
                           : wr_mask2[P + indicator_pkg::BIT_ENABLED];
      assign d_n = wr_data[P + indicator_pkg::BIT_UNACKED];
      assign d_e = wr_data[P + indicator_pkg::BIT_ENABLED];
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          alarm_unacked[a] <= 1'b0;
        end else if (alarm_raise[a]) begin
          alarm_unacked[a] <= 1'b1;
        end else if (m_n) begin
          alarm_unacked[a] <= d_n;
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          alarm_enabled[a] <= 1'b0;
        end else if (m_e) begin
          alarm_enabled[a] <= d_e;
        end
      end
    end
  endgenerate

  // Read-only sources sampled, writes never reach them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_act_q <= 8'h00;
      cfg_q       <= 1'b0;
      act_evt_q   <= 1'b0;
    end else begin
      alarm_act_q <= alarm_active;
      cfg_q       <= config_changed_flag;
      act_evt_q   <= active_event_flag;
    end
  end

  // Out-of-service controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_word_alarms_off_service  <= 1'b0;
      second_word_alarms_off_service <= 1'b0;
    end else begin
      if (wr_mask1[indicator_pkg::BIT_OFF_SERVICE]) begin
        first_word_alarms_off_service <= wr_data[indicator_pkg::BIT_OFF_SERVICE];
      end
      if (wr_mask2[indicator_pkg::BIT_OFF_SERVICE]) begin
        second_word_alarms_off_service <= wr_data[indicator_pkg::BIT_OFF_SERVICE];
      end
    end
  end

  // Unacknowledged event flag, event set wins over a write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unacked_event_flag <= 1'b0;
    end else if (loop_event_raise) begin
      unacked_event_flag <= 1'b1;
    end else if (wr_mask2[indicator_pkg::BIT_UNACK_EVT]) begin
      unacked_event_flag <= wr_data[indicator_pkg::BIT_UNACK_EVT];
    end
  end

  // Pushbutton presses from writes of one
  generate
    for (genvar b = 0; b < 3; b++) begin : g_button
      assign press[b] = wr_mask1[indicator_pkg::BIT_BUTTON_ONE + b]
                      & wr_data[indicator_pkg::BIT_BUTTON_ONE + b];
      button_switch u_switch (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .scan_tick          (scan_tick),
        .press              (press[b]),
        .sustained          (button_sustained[b]),
        .switch_input_state (switch_input_state[b])
      );
    end
  endgenerate

  // Word assembly
  always_comb begin
    next_w1 = indicator_pkg::WORD_ONE_RESET;
    next_w2 = indicator_pkg::WORD_TWO_RESET;
    for (int i = 0; i < 4; i++) begin
      next_w1[i*3 + indicator_pkg::BIT_ACTIVE]  = alarm_act_q[i];
      next_w1[i*3 + indicator_pkg::BIT_UNACKED] = alarm_unacked[i];
      next_w1[i*3 + indicator_pkg::BIT_ENABLED] = alarm_enabled[i];
      next_w2[i*3 + indicator_pkg::BIT_ACTIVE]  = alarm_act_q[i+4];
      next_w2[i*3 + indicator_pkg::BIT_UNACKED] = alarm_unacked[i+4];
      next_w2[i*3 + indicator_pkg::BIT_ENABLED] = alarm_enabled[i+4];
    end
    next_w1[indicator_pkg::BIT_OFF_SERVICE]  = first_word_alarms_off_service;
    next_w1[indicator_pkg::BIT_BUTTON_ONE]   = switch_input_state[0];
    next_w1[indicator_pkg::BIT_BUTTON_TWO]   = switch_input_state[1];
    next_w1[indicator_pkg::BIT_BUTTON_THREE] = switch_input_state[2];
    next_w2[indicator_pkg::BIT_OFF_SERVICE]  = second_word_alarms_off_service;
    next_w2[indicator_pkg::BIT_CONFIG_CHG]   = cfg_q;
    next_w2[indicator_pkg::BIT_UNACK_EVT]    = unacked_event_flag;
    next_w2[indicator_pkg::BIT_ACTIVE_EVT]   = act_evt_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_alarm_and_switch_word <= indicator_pkg::WORD_ONE_RESET;
      loop_alarm_and_event_word  <= indicator_pkg::WORD_TWO_RESET;
    end else begin
      loop_alarm_and_switch_word <= next_w1;
      loop_alarm_and_event_word  <= next_w2;
    end
  end

  // Coil read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coil_rdata <= 1'b0;
      coil_hit   <= 1'b0;
    end else begin
      coil_hit   <= coil_rd && coil_word != indicator_pkg::WORD_SEL_NONE;
      coil_rdata <= 1'b0;
      if (coil_rd && coil_word == indicator_pkg::WORD_SEL_ONE) begin
        coil_rdata <= next_w1[coil_bit];
      end else if (coil_rd && coil_word == indicator_pkg::WORD_SEL_TWO) begin
        coil_rdata <= next_w2[coil_bit];
      end
    end
  end
endmodule : analog_indicator_loop

/* File: shared/indicator_pkg.sv */
// Constants for the analog indicator loop status bit bank
package indicator_pkg;
  localparam int unsigned COIL_W          = 16;
  localparam logic [15:0] COIL_BASE       = 16'd296;
  localparam logic [15:0] COIL_LOOP_STEP  = 16'd48;
  localparam logic [15:0] COIL_WORD2_OFS  = 16'd16;
  localparam int unsigned LOOP_W          = 4;
  localparam logic [1:0]  WORD_SEL_ONE    = 2'h0;
  localparam logic [1:0]  WORD_SEL_TWO    = 2'h1;
  localparam logic [1:0]  WORD_SEL_NONE   = 2'h2;
  localparam int unsigned ALARMS          = 4;
  localparam int unsigned BIT_ACTIVE      = 0;
  localparam int unsigned BIT_UNACKED     = 1;
  localparam int unsigned BIT_ENABLED     = 2;
  localparam int unsigned BIT_OFF_SERVICE = 12;
  localparam int unsigned BIT_BUTTON_ONE  = 13;
  localparam int unsigned BIT_BUTTON_TWO  = 14;
  localparam int unsigned BIT_BUTTON_THREE = 15;
  localparam int unsigned BIT_CONFIG_CHG  = 13;
  localparam int unsigned BIT_UNACK_EVT   = 14;
  localparam int unsigned BIT_ACTIVE_EVT  = 15;
  localparam logic [15:0] WORD_ONE_RESET  = 16'h0000;
  localparam logic [15:0] WORD_TWO_RESET  = 16'h0000;
  localparam logic [2:0]  BUTTON_RESET    = 3'h0;
endpackage : indicator_pkg

/* File: logic/button_switch.sv */
// One pushbutton switch: sustained toggle or momentary one-scan closure
`timescale 1ns/10ps
module button_switch (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic scan_tick,
  input  wire logic press,
  input  wire logic sustained,
  // State
  output logic      switch_input_state
);
  logic pending;

  // Latch a press until the next scan
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (press) begin
      pending <= 1'b1;
    end else if (scan_tick) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_input_state <= 1'b0;
    end else if (scan_tick) begin
      if (sustained) begin
        if (pending) begin
          switch_input_state <= ~switch_input_state;
        end
      end else begin
        switch_input_state <= pending;
      end
    end
  end
endmodule : button_switch

/* File: bench/indicator_chk.sv */
// Assertion checker for the indicator loop status bank
`timescale 1ns/10ps
module indicator_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Requests
  input wire logic [3:0]  loop_number,
  input wire logic        scan_tick,
  input wire logic        word_wr,
  input wire logic        coil_wr,
  input wire logic        coil_rd,
  input wire logic [15:0] coil_addr,
  input wire logic        coil_wdata,
  // Outputs
  input wire logic [15:0] loop_alarm_and_switch_word,
  input wire logic [15:0] loop_alarm_and_event_word,
  input wire logic        coil_rdata,
  input wire logic        coil_hit,
  input wire logic [7:0]  alarm_unacked,
  input wire logic [7:0]  alarm_enabled,
  input wire logic        first_word_alarms_off_service,
  input wire logic        second_word_alarms_off_service,
  input wire logic        unacked_event_flag,
  input wire logic [2:0]  switch_input_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [15:0] w1  = loop_alarm_and_switch_word;
  wire logic [15:0] w2  = loop_alarm_and_event_word;
  wire logic [15:0] ofs = coil_addr - (16'd296 + 16'd48 * ({12'h0, loop_number} - 16'd1));
  sequence en_coil_wr;
    coil_wr && !word_wr && ofs == 16'd2;
  endsequence
  sequence far_coil_rd;
    coil_rd && ofs > 16'd31;
  endsequence
  unack_word_one_a: assert property (
    {w1[10], w1[7], w1[4], w1[1]} == $past(alarm_unacked[3:0])) else $error("unacked map");
  enab_word_two_a: assert property (
    {w2[11], w2[8], w2[5], w2[2]} == $past(alarm_enabled[7:4])) else $error("enabled map");
  off_service_a: assert property ({w1[12], w2[12]} ==
    $past({first_word_alarms_off_service, second_word_alarms_off_service})) else $error("os");
  button_map_a: assert property (
    w1[15:13] == $past(switch_input_state)) else $error("button map");
  event_map_a: assert property (w2[14] == $past(unacked_event_flag)) else $error("event");
  coil_write_a: assert property (
    en_coil_wr |=> alarm_enabled[0] == $past(coil_wdata)) else $error("coil write");
  coil_miss_a: assert property (
    far_coil_rd |=> !coil_hit && !coil_rdata) else $error("unmapped coil");
  tick_only_a: assert property (
    $changed(switch_input_state) |-> $past(scan_tick)) else $error("switch off tick");
endmodule : indicator_chk

bind analog_indicator_loop indicator_chk chk (.core_clk, .rst_n, .loop_number, .scan_tick,
  .word_wr, .coil_wr, .coil_rd, .coil_addr, .coil_wdata, .loop_alarm_and_switch_word,
  .loop_alarm_and_event_word, .coil_rdata, .coil_hit, .alarm_unacked, .alarm_enabled,
  .first_word_alarms_off_service, .second_word_alarms_off_service, .unacked_event_flag,
  .switch_input_state);

/* File: bench/net_master.sv */
// Network master model issuing word and coil requests
`timescale 1ns/10ps
module net_master (
  // Clock
  input  wire logic        core_clk,
  // Requests
  output logic             word_wr,
  output logic             word_sel,
  output logic [15:0]      word_wdata,
  output logic             coil_wr,
  output logic             coil_rd,
  output logic [15:0]      coil_addr,
  output logic             coil_wdata,
  // Answers
  input  wire logic        coil_rdata,
  input  wire logic        coil_hit
);
  initial begin
    {word_wr, word_sel, coil_wr, coil_rd, coil_wdata} = 5'h00;
    {word_wdata, coil_addr} = 32'hA5A55A5A;
  end
  task coil_write(input logic [15:0] a, input logic d);
    @(posedge core_clk);
    #1 {coil_addr, coil_wdata, coil_wr} = {a, d, 1'b1};
    @(posedge core_clk);
    #1 {coil_addr, coil_wdata, coil_wr} = {~a, ~d, 1'b0};
  endtask : coil_write
  task coil_read(input logic [15:0] a, output logic [1:0] res);
    @(posedge core_clk);
    #1 {coil_addr, coil_rd} = {a, 1'b1};
    @(posedge core_clk);
    #1 {coil_addr, coil_rd} = {~a, 1'b0};
    res = {coil_hit, coil_rdata};
  endtask : coil_read
  task word_write(input logic s, input logic [15:0] d);
    @(posedge core_clk);
    #1 {word_sel, word_wdata, word_wr} = {s, d, 1'b1};
    @(posedge core_clk);
    #1 {word_sel, word_wdata, word_wr} = {~s, ~d, 1'b0};
  endtask : word_write
endmodule : net_master

/* File: bench/testbench.sv */
// Self-checking bench for the indicator loop status bank
`timescale 1ns/10ps
module testbench;
  logic core_clk, rst_n, scan_tick, word_wr, word_sel, coil_wr, coil_rd, coil_wdata;
  logic config_changed_flag, active_event_flag, loop_event_raise, coil_rdata, coil_hit;
  logic first_word_alarms_off_service, second_word_alarms_off_service, unacked_event_flag;
  logic [15:0] word_wdata, coil_addr, loop_alarm_and_switch_word, loop_alarm_and_event_word;
  logic [7:0]  alarm_active, alarm_raise, alarm_unacked, alarm_enabled;
  logic [2:0]  button_sustained, switch_input_state;
  logic [3:0]  loop_number;
  logic [1:0]  res;
  int          n_fail, cmp_count;
  localparam logic [15:0] BASE = 16'd392;
  analog_indicator_loop uut (.core_clk, .rst_n, .loop_number, .scan_tick, .word_wr,
    .word_sel, .word_wdata, .coil_wr, .coil_rd, .coil_addr, .coil_wdata, .alarm_active,
    .alarm_raise, .config_changed_flag, .active_event_flag, .loop_event_raise,
    .button_sustained, .loop_alarm_and_switch_word, .loop_alarm_and_event_word, .coil_rdata,
    .coil_hit, .alarm_unacked, .alarm_enabled, .first_word_alarms_off_service,
    .second_word_alarms_off_service, .unacked_event_flag, .switch_input_state);
  net_master master (.core_clk, .word_wr, .word_sel, .word_wdata, .coil_wr, .coil_rd,
    .coil_addr, .coil_wdata, .coil_rdata, .coil_hit);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task tick;
    @(posedge core_clk);
    #1 scan_tick = 1'b1;
    @(posedge core_clk);
    #1 scan_tick = 1'b0;
    wait_cyc(2);
  endtask : tick
  task t_coils;
    logic [15:0] a;
    for (int i = 0; i < 8; i++) begin
      a = BASE + 16'(i < 4 ? 2 + 3 * i : 6 + 3 * i);
      master.coil_write(a, 1'b1);
      master.coil_read(a, res);
      chk({14'h0, res}, 16'h0003);
    end
    chk({8'h0, alarm_enabled}, 16'h00FF);
    master.coil_read(BASE + 16'd32, res);
    chk({14'h0, res}, 16'h0000);
    master.coil_read(BASE - 16'd1, res);
    chk({14'h0, res}, 16'h0000);
    loop_number = 4'h1;
    master.coil_read(16'd298, res);
    chk({14'h0, res}, 16'h0003);
    loop_number = 4'h3;
  endtask : t_coils
  task t_words;
    config_changed_flag = 1'b1;
    master.word_write(1'b1, 16'hFFFF);
    wait_cyc(3);
    chk(loop_alarm_and_event_word, 16'h7DB6);
    {alarm_active, active_event_flag} = {8'hF0, 1'b1};
    master.word_write(1'b1, 16'h0000);
    wait_cyc(3);
    chk(loop_alarm_and_event_word, 16'hA249);
    master.word_write(1'b0, 16'h1FFF);
    wait_cyc(3);
    chk(loop_alarm_and_switch_word, 16'h1DB6);
    {alarm_raise, loop_event_raise} = {8'h10, 1'b1};
    wait_cyc(1);
    {alarm_raise, loop_event_raise} = {8'h00, 1'b0};
    wait_cyc(3);
    chk(loop_alarm_and_event_word, 16'hE24B);
  endtask : t_words
  task t_buttons;
    master.coil_write(BASE + 16'd13, 1'b1);
    master.coil_write(BASE + 16'd14, 1'b1);
    wait_cyc(2);
    chk({13'h0, switch_input_state}, 16'h0000);
    tick();
    chk({13'h0, loop_alarm_and_switch_word[15:13]}, 16'h0003);
    tick();
    chk({13'h0, switch_input_state}, 16'h0001);
    master.coil_write(BASE + 16'd13, 1'b0);
    tick();
    chk({13'h0, switch_input_state}, 16'h0001);
    master.coil_write(BASE + 16'd13, 1'b1);
    tick();
    chk({13'h0, switch_input_state}, 16'h0000);
  endtask : t_buttons
  task print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {rst_n, scan_tick, config_changed_flag, active_event_flag, loop_event_raise} = 5'h00;
    {alarm_active, alarm_raise, button_sustained} = 19'h00001;
    {n_fail, cmp_count} = {32'd0, 32'd0};
    loop_number = 4'h3;
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    wait_cyc(1);
    chk(loop_alarm_and_switch_word, 16'h0000);
    chk(loop_alarm_and_event_word, 16'h0000);
    t_coils();
    t_words();
    t_buttons();
    print_verdict();
  end
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
endmodule : testbench
